// [rtl/dskip_pkg.sv]
/*
  constants for the decrement-and-skip execution block: opcode fields,
  addressing limits, quarter-cycle phases and reset values.
  assumes nothing of its surroundings; shared by every design file.
*/
package dskip_pkg;

    // instruction word layout
    localparam int unsigned OPC_MSB = 15; // top of the opcode field
    localparam int unsigned OPC_LSB = 10; // bottom of the opcode field
    localparam int unsigned DEST_BIT = 9; // destination select bit
    localparam int unsigned ACC_BIT = 8; // access bank select bit
    localparam int unsigned FILE_MSB = 7; // top of the file address

    // opcodes of the two variants, upper six bits of the word
    localparam logic [5:0] OPC_SKIP_ZERO = 6'h0b; // 0010 11
    localparam logic [5:0] OPC_SKIP_NONZERO = 6'h13; // 0100 11

    // addressing
    localparam logic [7:0] INDEXED_MAX = 8'h5f; // indexed offset limit, 95
    localparam logic [7:0] ACCESS_SPLIT = 8'h80; // access bank lower/upper split
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0; // bank of the lower access half
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf; // bank of the upper access half

    // quarter-cycle phases of one instruction cycle
    localparam logic [1:0] PH_Q1 = 2'h0; // decode
    localparam logic [1:0] PH_Q2 = 2'h1; // read register
    localparam logic [1:0] PH_Q3 = 2'h2; // process data
    localparam logic [1:0] PH_Q4 = 2'h3; // write destination
    localparam int unsigned CLKS_PER_CYCLE = 4; // clocks per instruction cycle

    // reset values
    localparam logic [1:0] PHASE_RESET = 2'h0; // phase counter after reset
    localparam logic [11:0] ADDR_RESET = 12'h000; // data address after reset
    localparam logic [7:0] DATA_RESET = 8'h00; // data outputs after reset

    // execution states
    typedef enum logic [1:0] {
        ST_EXEC,
        ST_NOP_FIRST,
        ST_NOP_SECOND
    } exec_state_t;

endpackage

// [rtl/operand_address.sv]
/*
  operand address former: turns the file field, access bit and bank
  select into a 12-bit data address. purely combinational.
  assumes the bank select and index base are stable during a cycle.
*/
`timescale 1ns/10ps
module operand_address #(
    parameter int unsigned ADDR_W = 12 // data address width
) (
    input wire logic [7:0] file_addr, // file field of the instruction
    input wire logic access_sel, // 0 access bank, 1 banked
    input wire logic ext_set_en, // extended instruction set enabled
    input wire logic [3:0] bank_select_register, // bank for banked operands
    input wire logic [ADDR_W-1:0] index_base, // base for indexed literal offset
    output logic [ADDR_W-1:0] operand_addr, // resulting data address
    output logic indexed // indexed mode was used
);

    // elaboration-time guard: the bank and access splits assume 12 bits
    if (ADDR_W != 12) begin : g_width_check
        $error("operand_address: only a 12-bit data space is served");
    end

    // address selection; indexed mode outranks the plain access bank
    always_comb begin
        indexed = 1'b0;
        if (access_sel) begin
            operand_addr = {bank_select_register, file_addr};
        end else if (ext_set_en && (file_addr <= dskip_pkg::INDEXED_MAX)) begin
            indexed = 1'b1;
            // wraps within the data space on purpose
            operand_addr = index_base + {4'h0, file_addr};
        end else if (file_addr < dskip_pkg::ACCESS_SPLIT) begin
            operand_addr = {dskip_pkg::ACCESS_LOW_BANK, file_addr};
        end else begin
            operand_addr = {dskip_pkg::ACCESS_HIGH_BANK, file_addr};
        end
    end

endmodule // operand_address

// [rtl/decrement_skip_exec.sv]
/*
  execution logic for the decrement-and-skip byte instructions of an
  8-bit core: decode, operand read, decrement, write-back and the forced
  no-operation cycles of a skip.
  assumes the fetch path presents the instruction word from the first
  quarter of each cycle on, and data memory answers a read within the
  same quarter (read data valid in the quarter that the read strobe is high).
*/
`timescale 1ns/10ps
// What this block does
// - decrement file register, result to accumulator or file
// - nonzero variant skips next instruction on nonzero
// - access bit selects access or banked operand
// - indexed offset when extended, access, address below 60h
// - decode nonzero variant from opcode 0100 11
// - decode zero variant 0010 11, skip on zero
// - skipped two-word instruction costs a second nop
module decrement_skip_exec (
    input wire logic clk, // core clock, four per instruction cycle
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [15:0] instr_word, // fetched instruction word
    input wire logic next_two_word, // prefetched next instruction is two words
    input wire logic ext_set_en, // extended instruction set enabled
    input wire logic [3:0] bank_select_register, // current bank select
    input wire logic [11:0] index_base, // base for indexed literal offset
    input wire logic [7:0] mem_rd_data, // data memory read data
    output logic [1:0] phase_q, // current quarter, 0 is the first
    output logic hit_q, // one of our instructions is executing
    output logic nop_q, // this cycle is a forced no-operation
    output logic flush_q, // discard the fetched instruction, one clock pulse
    output logic [11:0] mem_addr_q, // data memory address
    output logic mem_rd_q, // data memory read strobe
    output logic mem_wr_q, // data memory write strobe
    output logic [7:0] mem_wr_data_q, // data memory write data
    output logic wreg_wr_q, // accumulator write strobe
    output logic [7:0] wreg_data_q, // accumulator write data
    output logic flags_wr_q, // status flag write strobe, held low
    output logic pc_words_q // program words taken by this instruction
);

    // per-instruction latched decode
    logic [1:0] phase_d;
    dskip_pkg::exec_state_t state_q, state_d;
    logic hit_d, nop_d, flush_d;
    logic is_nonzero_q, is_nonzero_d; // which variant is executing
    logic dest_q, dest_d; // destination bit of the instruction
    logic [7:0] file_q, file_d; // file field of the instruction
    logic access_q, access_d; // access bit of the instruction
    logic [7:0] result_q, result_d; // decremented operand
    logic skip_q, skip_d; // skip decided in the third quarter
    logic [11:0] mem_addr_d;
    logic mem_rd_d, mem_wr_d, wreg_wr_d, pc_words_d;
    logic [7:0] mem_wr_data_d, wreg_data_d;

    // decode of the word on the fetch path
    logic [5:0] opcode; // upper six bits of the word
    logic match_zero, match_nonzero; // variant matches
    logic [11:0] operand_addr; // address from the former

    assign opcode = instr_word[dskip_pkg::OPC_MSB:dskip_pkg::OPC_LSB];
    assign match_zero = (opcode == dskip_pkg::OPC_SKIP_ZERO);
    assign match_nonzero = (opcode == dskip_pkg::OPC_SKIP_NONZERO);

    // address former works off the latched fields, so a fetch that
    // changes the word mid-cycle cannot move the operand address
    operand_address #(
        .ADDR_W(12)
    ) u_addr (
        .file_addr(file_q),
        .access_sel(access_q),
        .ext_set_en(ext_set_en),
        .bank_select_register(bank_select_register),
        .index_base(index_base),
        .operand_addr(operand_addr),
        .indexed()
    );

    // next-state logic for the whole instruction cycle
    always_comb begin
        phase_d = phase_q + 2'h1; // free-running quarter divider
        state_d = state_q;
        hit_d = hit_q;
        nop_d = nop_q;
        flush_d = 1'b0;
        is_nonzero_d = is_nonzero_q;
        dest_d = dest_q;
        file_d = file_q;
        access_d = access_q;
        result_d = result_q;
        skip_d = skip_q;
        mem_addr_d = mem_addr_q;
        mem_rd_d = 1'b0;
        mem_wr_d = 1'b0;
        mem_wr_data_d = mem_wr_data_q;
        wreg_wr_d = 1'b0;
        wreg_data_d = wreg_data_q;
        pc_words_d = pc_words_q;
        unique case (phase_q)
            dskip_pkg::PH_Q1: begin
                // decode, or burn a quarter of a forced nop
                unique case (state_q)
                    dskip_pkg::ST_EXEC: begin
                        hit_d = match_zero || match_nonzero;
                        nop_d = 1'b0;
                        skip_d = 1'b0;
                        is_nonzero_d = match_nonzero;
                        dest_d = instr_word[dskip_pkg::DEST_BIT];
                        access_d = instr_word[dskip_pkg::ACC_BIT];
                        file_d = instr_word[dskip_pkg::FILE_MSB:0];
                        // one program word; the next word is never claimed
                        pc_words_d = 1'b1;
                    end
                    dskip_pkg::ST_NOP_FIRST, dskip_pkg::ST_NOP_SECOND: begin
                        // the prefetched word is thrown away unexecuted
                        hit_d = 1'b1;
                        nop_d = 1'b1;
                    end
                endcase
            end
            dskip_pkg::PH_Q2: begin
                // read register f
                if ((state_q == dskip_pkg::ST_EXEC) && hit_q) begin
                    mem_addr_d = operand_addr;
                    mem_rd_d = 1'b1;
                end
            end
            dskip_pkg::PH_Q3: begin
                // process data: decrement and decide the skip
                if ((state_q == dskip_pkg::ST_EXEC) && hit_q) begin
                    result_d = mem_rd_data - 8'h01;
                    if (is_nonzero_q) begin
                        skip_d = (mem_rd_data != 8'h01);
                    end else begin
                        skip_d = (mem_rd_data == 8'h01);
                    end
                end
            end
            dskip_pkg::PH_Q4: begin
                // write destination and pick the next cycle's role
                unique case (state_q)
                    dskip_pkg::ST_EXEC: begin
                        if (hit_q) begin
                            if (dest_q) begin
                                mem_wr_d = 1'b1;
                                mem_wr_data_d = result_q;
                            end else begin
                                wreg_wr_d = 1'b1;
                                wreg_data_d = result_q;
                            end
                            if (skip_q) begin
                                flush_d = 1'b1;
                                state_d = dskip_pkg::ST_NOP_FIRST;
                            end
                        end
                    end
                    dskip_pkg::ST_NOP_FIRST: begin
                        // a skipped two-word instruction needs a second nop
                        if (next_two_word) begin
                            flush_d = 1'b1;
                            state_d = dskip_pkg::ST_NOP_SECOND;
                        end else begin
                            state_d = dskip_pkg::ST_EXEC;
                        end
                    end
                    dskip_pkg::ST_NOP_SECOND: begin
                        state_d = dskip_pkg::ST_EXEC;
                    end
                endcase
            end
        endcase
    end

    // registers; flag strobe is tied low in reset and never raised,
    // so no arithmetic flag moves for either variant
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_q <= dskip_pkg::PHASE_RESET;
            state_q <= dskip_pkg::ST_EXEC;
            hit_q <= 1'b0;
            nop_q <= 1'b0;
            flush_q <= 1'b0;
            is_nonzero_q <= 1'b0;
            dest_q <= 1'b1;
            file_q <= dskip_pkg::DATA_RESET;
            access_q <= 1'b1;
            result_q <= dskip_pkg::DATA_RESET;
            skip_q <= 1'b0;
            mem_addr_q <= dskip_pkg::ADDR_RESET;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_wr_data_q <= dskip_pkg::DATA_RESET;
            wreg_wr_q <= 1'b0;
            wreg_data_q <= dskip_pkg::DATA_RESET;
            flags_wr_q <= 1'b0;
            pc_words_q <= 1'b1;
        end else begin
            phase_q <= phase_d;
            state_q <= state_d;
            hit_q <= hit_d;
            nop_q <= nop_d;
            flush_q <= flush_d;
            is_nonzero_q <= is_nonzero_d;
            dest_q <= dest_d;
            file_q <= file_d;
            access_q <= access_d;
            result_q <= result_d;
            skip_q <= skip_d;
            mem_addr_q <= mem_addr_d;
            mem_rd_q <= mem_rd_d;
            mem_wr_q <= mem_wr_d;
            mem_wr_data_q <= mem_wr_data_d;
            wreg_wr_q <= wreg_wr_d;
            wreg_data_q <= wreg_data_d;
            flags_wr_q <= 1'b0;
            pc_words_q <= pc_words_d;
        end
    end

endmodule // decrement_skip_exec

// [verification/decrement_skip_exec_assertions.sv]
/*
  checker for the decrement-and-skip block: timing of read, write and skip.
  assumes the instruction word and read data are held for the whole cycle.
*/
`timescale 1ns/10ps
module decrement_skip_checker (
    input wire logic clk, // core clock
    input wire logic rst_n, // reset, active low
    input wire logic [15:0] instr_word, // fetched word
    input wire logic next_two_word, // next word is long
    input wire logic [3:0] bank_select_register, // bank
    input wire logic [7:0] mem_rd_data, // operand
    input wire logic [1:0] phase_q, // quarter
    input wire logic hit_q, // our instruction
    input wire logic nop_q, // forced nop
    input wire logic flush_q, // discard pulse
    input wire logic [11:0] mem_addr_q, // operand address
    input wire logic mem_rd_q, // read strobe
    input wire logic mem_wr_q, // file write
    input wire logic [7:0] mem_wr_data_q, // file data
    input wire logic wreg_wr_q, // accumulator write
    input wire logic [7:0] wreg_data_q, // accumulator data
    input wire logic flags_wr_q, // flag write
    input wire logic pc_words_q // program words
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // any result write, seen four clocks after decode
    wire wr = mem_wr_q | wreg_wr_q;
    a_flags_kept: assert property (!flags_wr_q) else $error("flags written");
    a_one_word: assert property (pc_words_q) else $error("word count");
    a_one_dest: assert property (!(mem_wr_q && wreg_wr_q)) else $error("two dests");
    a_read_first: assert property (wr |-> $past(mem_rd_q, 2)) else $error("no read");
    a_dest_bit: assert property (wr |-> mem_wr_q == $past(instr_word[9], 4))
        else $error("wrong dest");
    a_result_value: assert property (wr |-> (mem_wr_q ? mem_wr_data_q : wreg_data_q)
        == $past(mem_rd_data, 2) - 8'h01) else $error("bad result");
    a_zero_skip: assert property (wr && $past(instr_word[15:10], 4) == 6'h0b
        |-> flush_q == ($past(mem_rd_data, 2) == 8'h01)) else $error("zero skip");
    a_nonzero_skip: assert property (wr && $past(instr_word[15:10], 4) == 6'h13
        |-> flush_q == ($past(mem_rd_data, 2) != 8'h01)) else $error("nz skip");
    a_nop_follows: assert property (wr && flush_q |=> nop_q [*4]) else $error("no nop");
    a_two_word: assert property (wr && flush_q && next_two_word |-> ##[2:6] flush_q)
        else $error("no second nop");
    a_one_word_skip: assert property (wr && flush_q && !next_two_word
        |=> !flush_q [*7]) else $error("extra nop");
    a_banked_addr: assert property (mem_rd_q && $past(instr_word[8], 2) |->
        mem_addr_q == {$past(bank_select_register, 2), $past(instr_word[7:0], 2)})
        else $error("bank");
    // quarter counter never skips or stalls once out of reset
    a_phase_steps: assert property ($past(rst_n) |->
        phase_q == $past(phase_q) + 2'h1) else $error("phase skipped");
    // a decoded cycle is ours exactly when the opcode matched at decode
    a_hit_decode: assert property (phase_q == 2'h1 && !nop_q |-> hit_q ==
        ($past(instr_word[15:10]) == 6'h0b || $past(instr_word[15:10]) == 6'h13))
        else $error("bad decode");
    a_read_ours: assert property (mem_rd_q |-> hit_q && !nop_q)
        else $error("stray read");
    c_skip: cover property (wr && flush_q);
    c_long_skip: cover property (wr && flush_q && next_two_word);
    c_to_acc: cover property (wreg_wr_q);
endmodule // decrement_skip_checker

bind decrement_skip_exec decrement_skip_checker u_chk (.clk, .rst_n, .instr_word,
    .next_two_word, .bank_select_register, .mem_rd_data, .phase_q, .hit_q, .nop_q, .flush_q,
    .mem_addr_q,
    .mem_rd_q, .mem_wr_q, .mem_wr_data_q, .wreg_wr_q, .wreg_data_q, .flags_wr_q, .pc_words_q);

// [verification/decrement_skip_exec_bench.sv]
/*
  self-checking bench for the decrement-and-skip block: directed corners
  then random words; expectations queued by the driver, checked on writes.
  assumes each instruction's inputs may be held until the next one.
*/
`timescale 1ns/10ps
module decrement_skip_exec_bench;
    logic clk = 1'b0; // core clock
    logic rst_n = 1'b0; // reset, active low
    logic [15:0] instr_word = 16'h0000; // word under test
    logic next_two_word = 1'b0; // skipped instruction is two words long
    logic ext_set_en = 1'b0; // extended set enable
    logic [3:0] bank_select_register = 4'h0; // bank
    logic [11:0] index_base = 12'h000; // indexed base
    logic [7:0] mem_rd_data = 8'h00; // operand value
    logic [1:0] phase_q; // quarter
    logic hit_q, nop_q, flush_q, mem_rd_q, mem_wr_q, wreg_wr_q, flags_wr_q, pc_words_q; // status
    logic [11:0] mem_addr_q; // operand address
    logic [7:0] mem_wr_data_q, wreg_data_q; // results
    logic [31:0] seed = 32'h00007171; // xorshift state
    logic [22:0] exp_q[$]; // {file, acc, skip, addr, data}
    logic [22:0] exp_now; // oldest expectation, popped once per write
    int fails = 0; // mismatches
    int checked = 0; // comparisons
    int flushes = 0; // discard pulses seen
    int flush_exp = 0; // discard pulses expected
    int cyc = 0; // timeout counter
    int i; // loop index
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

    decrement_skip_exec DUT (.clk, .rst_n, .instr_word, .next_two_word, .ext_set_en,
        .bank_select_register, .index_base, .mem_rd_data, .phase_q, .hit_q, .nop_q, .flush_q,
        .mem_addr_q, .mem_rd_q, .mem_wr_q, .mem_wr_data_q, .wreg_wr_q, .wreg_data_q,
        .flags_wr_q, .pc_words_q);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // one instruction: drive, queue the expectation, wait out its cycles
    task automatic issue(input logic [15:0] w, input logic [7:0] v);
        logic [31:0] t;
        logic [11:0] a;
        logic s;
        t = rnd();
        s = (w[15:10] == dskip_pkg::OPC_SKIP_ZERO) ? (v == 8'h01) : (v != 8'h01);
        if (w[8]) a = {t[11:8], w[7:0]};
        else if (t[12] && w[7:0] <= dskip_pkg::INDEXED_MAX) a = t[27:16] + {4'h0, w[7:0]};
        else a = {w[7] ? dskip_pkg::ACCESS_HIGH_BANK : dskip_pkg::ACCESS_LOW_BANK, w[7:0]};
        instr_word <= w;
        mem_rd_data <= v;
        bank_select_register <= t[11:8];
        ext_set_en <= t[12];
        next_two_word <= t[13];
        index_base <= t[27:16];
        // words of other opcodes must leave no trace at all
        if (w[15:10] == dskip_pkg::OPC_SKIP_ZERO || w[15:10] == dskip_pkg::OPC_SKIP_NONZERO) begin
            exp_q.push_back({w[9], !w[9], s, a, v - 8'h01});
            flush_exp += s + (s & t[13]);
        end else begin
            s = 1'b0;
        end
        repeat (4 * (1 + s + (s & t[13]))) @(posedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        forever #50 clk = ~clk;
    end

    // hang guard, well above the at most 1357 clocks needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    // result watcher: every write pops the oldest expectation; it looks on
    // the falling edge, where strobes launched by the rising edge have settled
    always @(negedge clk) begin
        if (flush_q === 1'b1) flushes++;
        if (mem_wr_q === 1'b1 || wreg_wr_q === 1'b1) begin
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                // popped into a variable: the macro names its arguments twice
                exp_now = exp_q.pop_front();
                `CHK({mem_wr_q, wreg_wr_q, flush_q, mem_addr_q,
                    mem_wr_q ? mem_wr_data_q : wreg_data_q}, exp_now)
            end
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // corners: both opcodes, d, a, indexed limit, results zero and wrap
        for (i = 0; i < 32; i++) begin
            issue({i[0] ? dskip_pkg::OPC_SKIP_NONZERO : dskip_pkg::OPC_SKIP_ZERO, i[1], i[2],
                i[3] ? 8'h5f : 8'h60}, {6'h00, i[4:3]});
        end
        // random words, about half of them not ours
        for (i = 0; i < 80; i++) begin
            seed = rnd();
            issue({seed[1:0] == 2'h0 ? dskip_pkg::OPC_SKIP_ZERO : seed[1:0] == 2'h1 ?
                dskip_pkg::OPC_SKIP_NONZERO : seed[21:16], seed[31:22]}, seed[9:2]);
        end
        repeat (8) @(posedge clk);
        `CHK(flushes, flush_exp)
        `CHK(exp_q.size(), 0)
        tally_and_finish();
    end
endmodule // decrement_skip_exec_bench
